// file: rtl/sar_ctrl.sv
`timescale 1ns/1ns
module sar_ctrl (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic HFOSC_TICK,
	input wire logic TIMER_OVF,
	input wire logic EXTERNAL_CONVERT_START,
	input wire logic CORE_DONE,
	input wire logic [11:0] CORE_DATA,
	output sar_pkg::core_t CORE_CTL,
	output logic CONVERSION_CLOCK
);
	sar_pkg::ctrl_t ctrl_r;
	sar_pkg::cfg_t cfg_r;
	logic [4:0] input_channel_select_r;
	logic [15:0] result_r;
	logic [15:0] acc_r;
	logic [15:0] sum;
	logic [11:0] sample;
	logic [6:0] cnt_r;
	logic [6:0] target;
	logic [4:0] div_r;
	logic [3:0] tmr_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic pin_r;
	logic sar_tick;
	logic base_tick;
	logic wr_now;
	logic sw_start;
	logic ext_rise;
	logic trig;
	logic last;
	logic ext_dtrack;
	logic conv_start;
	sar_pkg::state_t state_r, state_nxt;
	sar_pkg::core_t core_nxt;

	// single wait cycle; writes land on the edge waitrequest is low
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
	assign wr_now = AVS_WRITE & ack_r;
	assign AVS_READDATA = rdata_r;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rdata_r <= 32'h0;
		end else if (AVS_READ & ~ack_r) begin
			case (AVS_ADDRESS)
				sar_pkg::OFS_CTRL: rdata_r <= {25'h0, ctrl_r};
				sar_pkg::OFS_CFG: rdata_r <= {18'h0, cfg_r};
				sar_pkg::OFS_MUX: rdata_r <= {27'h0, input_channel_select_r};
				sar_pkg::OFS_RES_HI: rdata_r <= {24'h0, result_r[15:8]};
				sar_pkg::OFS_RES_LO: rdata_r <= {24'h0, result_r[7:0]};
				default: rdata_r <= 32'h0;
			endcase
		end
	end

	// conversion clock: divided system clock, or oscillator ticks in burst
	assign base_tick = ctrl_r.burst ? HFOSC_TICK : 1'b1;
	assign sar_tick = base_tick & (div_r == cfg_r.div);
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			div_r <= 5'h0;
		end else if (sar_tick) begin
			div_r <= 5'h0;
		end else if (base_tick) begin
			div_r <= div_r + 5'h1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			CONVERSION_CLOCK <= 1'b0;
		end else begin
			CONVERSION_CLOCK <= sar_tick;
		end
	end

	assign sw_start = wr_now & (AVS_ADDRESS == sar_pkg::OFS_CTRL) & AVS_WRITEDATA[0];
	assign ext_rise = EXTERNAL_CONVERT_START & ~pin_r;
	// sample instants come from triggers and tracking, never from the divider alone
	always_comb begin
		case (ctrl_r.src)
			sar_pkg::SRC_SW: trig = sw_start;
			sar_pkg::SRC_TMR: trig = TIMER_OVF;
			sar_pkg::SRC_EXT: trig = ext_rise;
			default: trig = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= EXTERNAL_CONVERT_START;
		end
	end

	assign target = ctrl_r.burst ? sar_pkg::rpt_count(cfg_r.rpt) : 7'h01;
	assign last = (cnt_r + 7'h1) >= target;
	assign ext_dtrack = ~ctrl_r.burst & (ctrl_r.src == sar_pkg::SRC_EXT);

	// triggers outside idle fall through untouched
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sar_pkg::ST_IDLE: begin
				if (trig) begin
					if (ctrl_r.burst & ~ctrl_r.pwr_on) begin
						state_nxt = sar_pkg::ST_PWRUP;
					end else if (ctrl_r.dtrack & ~ext_dtrack) begin
						state_nxt = sar_pkg::ST_TRACK;
					end else begin
						state_nxt = sar_pkg::ST_CONV;
					end
				end
			end
			sar_pkg::ST_PWRUP: begin
				if (sar_tick & (tmr_r >= cfg_r.pwr_time)) begin
					state_nxt = ctrl_r.dtrack ? sar_pkg::ST_TRACK : sar_pkg::ST_CONV;
				end
			end
			sar_pkg::ST_TRACK: begin
				if (sar_tick & (tmr_r == sar_pkg::TRACK_CLKS - 4'h1)) begin
					state_nxt = sar_pkg::ST_CONV;
				end
			end
			sar_pkg::ST_CONV: begin
				if (CORE_DONE) begin
					if (last) begin
						state_nxt = sar_pkg::ST_IDLE;
					end else if (ctrl_r.dtrack) begin
						state_nxt = sar_pkg::ST_TRACK;
					end
				end
			end
			default: state_nxt = sar_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_r <= sar_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tmr_r <= 4'h0;
		end else if (state_nxt != state_r) begin
			tmr_r <= 4'h0;
		end else if (sar_tick & (tmr_r != 4'hF)) begin
			tmr_r <= tmr_r + 4'h1;
		end
	end

	// 8-bit mode drops the two lsbs so the low two bits read zero
	assign sample = (cfg_r.res == sar_pkg::RES_8) ? {CORE_DATA[11:2], 2'b00} : CORE_DATA;
	assign sum = (cnt_r == 7'h0) ? {4'h0, sample} : acc_r + {4'h0, sample};

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cnt_r <= 7'h0;
			acc_r <= 16'h0;
		end else if ((state_r == sar_pkg::ST_IDLE) & trig) begin
			cnt_r <= 7'h0;
		end else if ((state_r == sar_pkg::ST_CONV) & CORE_DONE) begin
			cnt_r <= cnt_r + 7'h1;
			acc_r <= sum;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			result_r <= 16'h0;
		end else if ((state_r == sar_pkg::ST_CONV) & CORE_DONE & last) begin
			result_r <= sum;
		end
	end

	// done flag: hardware set beats a software clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_r <= sar_pkg::CTRL_RST;
		end else begin
			if (wr_now & (AVS_ADDRESS == sar_pkg::OFS_CTRL)) begin
				ctrl_r.burst <= AVS_WRITEDATA[6];
				ctrl_r.pwr_on <= AVS_WRITEDATA[5];
				ctrl_r.src <= AVS_WRITEDATA[4:3];
				ctrl_r.dtrack <= AVS_WRITEDATA[2];
				ctrl_r.done <= AVS_WRITEDATA[1] & ctrl_r.done;
			end
			if ((state_r == sar_pkg::ST_CONV) & CORE_DONE & last) begin
				ctrl_r.done <= 1'b1;
			end
			ctrl_r.busy <= state_nxt != sar_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cfg_r <= sar_pkg::CFG_RST;
		end else if (wr_now & (AVS_ADDRESS == sar_pkg::OFS_CFG)) begin
			cfg_r <= AVS_WRITEDATA[13:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			input_channel_select_r <= sar_pkg::MUX_RST;
		end else if (wr_now & (AVS_ADDRESS == sar_pkg::OFS_MUX)) begin
			input_channel_select_r <= AVS_WRITEDATA[4:0];
		end
	end

	assign conv_start = (state_nxt == sar_pkg::ST_CONV) &
		((state_r != sar_pkg::ST_CONV) | CORE_DONE);
	always_comb begin
		core_nxt.chan = input_channel_select_r;
		core_nxt.connect = input_channel_select_r <= sar_pkg::CH_LAST;
		core_nxt.res = cfg_r.res;
		core_nxt.start = conv_start;
		// burst keeps the core off between bursts unless power-on holds it
		core_nxt.power = ctrl_r.pwr_on | (ctrl_r.burst & (state_nxt != sar_pkg::ST_IDLE));
		core_nxt.track = (state_nxt == sar_pkg::ST_TRACK) |
			((state_nxt == sar_pkg::ST_IDLE) & ~ctrl_r.burst & ~ctrl_r.dtrack) |
			((state_nxt == sar_pkg::ST_IDLE) & ext_dtrack & ctrl_r.dtrack &
			~EXTERNAL_CONVERT_START);
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			CORE_CTL <= '0;
		end else begin
			CORE_CTL <= core_nxt;
		end
	end

	sequence idle_trig_s;
		(state_r == sar_pkg::ST_IDLE) && trig;
	endsequence
	sequence last_done_s;
		(state_r == sar_pkg::ST_CONV) && CORE_DONE && last;
	endsequence

	chan_connect_a: assert property (@(posedge REF_CLK) disable iff (RST)
		1'b1 |=> CORE_CTL.connect == ($past(input_channel_select_r) <= 5'h13))
		else $error("connect does not match channel code");
	div_ratio_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(sar_tick && !ctrl_r.burst && cfg_r.div == 5'h1 && !wr_now) ##1 !wr_now
		|-> !sar_tick ##1 sar_tick)
		else $error("conversion clock not divided by ratio");
	sw_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(idle_trig_s and (ctrl_r.src == sar_pkg::SRC_SW)) |=> ctrl_r.busy)
		else $error("software start did not begin conversion");
	tmr_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
		((state_r == sar_pkg::ST_IDLE) && ctrl_r.src == sar_pkg::SRC_TMR && TIMER_OVF)
		|=> state_r != sar_pkg::ST_IDLE)
		else $error("timer overflow ignored");
	ext_start_a: assert property (@(posedge REF_CLK) disable iff (RST)
		((state_r == sar_pkg::ST_IDLE) && ctrl_r.src == sar_pkg::SRC_EXT &&
		EXTERNAL_CONVERT_START && !pin_r) |=> state_r != sar_pkg::ST_IDLE)
		else $error("external rising edge ignored");
	done_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
		last_done_s |=> ctrl_r.done && !ctrl_r.busy && result_r == $past(sum))
		else $error("completion did not post result and flag");
	track_four_a: assert property (@(posedge REF_CLK) disable iff (RST)
		((state_r == sar_pkg::ST_TRACK) && sar_tick && tmr_r == 4'h3)
		|=> state_r == sar_pkg::ST_CONV && CORE_CTL.start)
		else $error("track interval not four conversion clocks");
	busy_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
		((state_r != sar_pkg::ST_IDLE) && sw_start && !CORE_DONE)
		|=> state_r != sar_pkg::ST_IDLE && $stable(cnt_r))
		else $error("busy write disturbed conversion");
	other_src_a: assert property (@(posedge REF_CLK) disable iff (RST)
		((state_r == sar_pkg::ST_IDLE) && ctrl_r.src == sar_pkg::SRC_TMR && sw_start &&
		!TIMER_OVF) |=> state_r == sar_pkg::ST_IDLE)
		else $error("unselected source started conversion");
	ext_track_a: assert property (@(posedge REF_CLK) disable iff (RST)
		((state_r == sar_pkg::ST_IDLE) && ext_dtrack && ctrl_r.dtrack)
		|=> CORE_CTL.track == !$past(EXTERNAL_CONVERT_START))
		else $error("pin low tracking wrong");
	burst_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(last_done_s ##0 (ctrl_r.burst && !ctrl_r.pwr_on))
		|=> !CORE_CTL.power)
		else $error("converter left powered after burst");
endmodule

// file: rtl/sar_pkg.sv
// Contract
// - channel codes 0-15 external, 16 temp, 17 regulator, 18 supply, 19 ground, rest none
// - conversion clock divides system clock, or oscillator ticks in burst mode
// - divide ratio comes from the clock divide field of the config register
// - conversion clock alone never sets sample instants; triggers and tracking do
// - start source field picks trigger; software writing busy=1 starts on demand
// - selected timer overflow starts a conversion
// - selected external pin rising edge starts a conversion
// - completion writes result high/low and sets the done flag
// - busy reads 1 throughout a conversion, 0 after it completes
// - delayed track off, no burst: track continuously, convert at once on trigger
// - delayed track, internal trigger: 4 conversion clocks of tracking first
// - delayed track, external trigger: track while pin low, convert on rising edge (in burst the code instead tracks 4 conversion clocks before converting)
// - 12, 10 and 8 bit resolutions selectable by software
// - 16-bit accumulator sums successive results
// - burst mode powers core up, accumulates, powers down autonomously
// - burst trigger runs repeat count conversions 1/4/8/16/32/64, then done
// - burst with power-on clear: power down after burst, power-up wait on next
// - burst ignores triggers until burst ends; triggers spaced four clocks or more
package sar_pkg;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CFG = 5'h04;
	localparam logic [4:0] OFS_MUX = 5'h08;
	localparam logic [4:0] OFS_RES_HI = 5'h0C;
	localparam logic [4:0] OFS_RES_LO = 5'h10;
	localparam logic [4:0] CH_LAST = 5'h13;
	localparam logic [1:0] SRC_SW = 2'h0;
	localparam logic [1:0] SRC_TMR = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] RES_10 = 2'h0;
	localparam logic [1:0] RES_8 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [3:0] TRACK_CLKS = 4'h4;
	typedef struct packed {
		logic burst;
		logic pwr_on;
		logic [1:0] src;
		logic dtrack;
		logic done;
		logic busy;
	} ctrl_t;
	typedef struct packed {
		logic [3:0] pwr_time;
		logic [2:0] rpt;
		logic [1:0] res;
		logic [4:0] div;
	} cfg_t;
	typedef struct packed {
		logic power;
		logic track;
		logic start;
		logic connect;
		logic [4:0] chan;
		logic [1:0] res;
	} core_t;
	localparam ctrl_t CTRL_RST = 7'h00;
	localparam cfg_t CFG_RST = 14'h001F;
	localparam logic [4:0] MUX_RST = 5'h1F;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PWRUP = 4'h2,
		ST_TRACK = 4'h4,
		ST_CONV = 4'h8
	} state_t;
	function automatic logic [6:0] rpt_count(input logic [2:0] code);
		case (code)
			3'h0: rpt_count = 7'h01;
			3'h1: rpt_count = 7'h04;
			3'h2: rpt_count = 7'h08;
			3'h3: rpt_count = 7'h10;
			3'h4: rpt_count = 7'h20;
			default: rpt_count = 7'h40;
		endcase
	endfunction
endpackage

// file: test/core_model.sv
`timescale 1ns/1ns
module core_model (
	input wire logic clk,
	input wire logic rst,
	input wire sar_pkg::core_t ctl,
	input wire logic [11:0] value,
	output logic done,
	output logic [11:0] data
);
	logic [3:0] cnt_r;
	// slow enough that a second busy write lands mid-conversion
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 4'h0;
		end else if (ctl.start) begin
			cnt_r <= 4'hC;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
	assign done = (cnt_r == 4'h1);
	// data only means anything with done
	assign data = done ? value : ~value;
endmodule

// file: test/test_sar_adc_conversion_control.sv
`timescale 1ns/1ns
module test_sar_adc_conversion_control;
	logic ref_clk, rst, rd, wr, wait_req, tovf, ext, cdone, cclk;
	logic hf = 1'b0;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [11:0] cdata;
	sar_pkg::core_t ctl;
	int fails, n_checks, t0, s0, n;
	int starts = 0;
	int cyc = 0;
	int last_st = 0;
	sar_ctrl i_dut (.REF_CLK(ref_clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .HFOSC_TICK(hf), .TIMER_OVF(tovf),
		.EXTERNAL_CONVERT_START(ext), .CORE_DONE(cdone), .CORE_DATA(cdata),
		.CORE_CTL(ctl), .CONVERSION_CLOCK(cclk));
	core_model i_core (.clk(ref_clk), .rst(rst), .ctl(ctl), .value(12'h2A5),
		.done(cdone), .data(cdata));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		hf <= ~hf;
		if (ctl.start === 1'b1) begin
			starts <= starts + 1;
			last_st <= cyc;
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (wait_req === 1'b0) begin
				q = rdata;
				break;
			end
		end
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) begin
			fails++;
			close_out();
		end
	endtask
	// done flag polled, not busy
	task automatic wait_done();
		int i;
		for (i = 0; i < 100; i++) begin
			bus(1'b0, sar_pkg::OFS_CTRL, 32'h0);
			if (q[1] === 1'b1)
				break;
		end
		chk("busy", 32'h0, {31'h0, q[0]});
		if (i == 100) begin
			fails++;
			close_out();
		end
	endtask
	task automatic result(input logic [7:0] hi, input logic [7:0] lo);
		bus(1'b0, sar_pkg::OFS_RES_HI, 32'h0);
		chk("res_hi", {24'h0, hi}, q);
		bus(1'b0, sar_pkg::OFS_RES_LO, 32'h0);
		chk("res_lo", {24'h0, lo}, q);
	endtask
	logic [4:0] codes [6] = '{5'h00, 5'h0F, 5'h10, 5'h13, 5'h14, 5'h1F};
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		tovf = 1'b0;
		ext = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		fails = 0;
		n_checks = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, sar_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0, q);
		bus(1'b0, sar_pkg::OFS_CFG, 32'h0);
		chk("cfg", 32'h1F, q);
		// divide ratio 2 with 12-bit resolution
		bus(1'b1, sar_pkg::OFS_CFG, 32'h41);
		bus(1'b0, sar_pkg::OFS_CFG, 32'h0);
		chk("cfg_wr", 32'h41, q);
		// the divider may sit above the new ratio and has to wrap first
		repeat (40) @(posedge ref_clk);
		n = 0;
		repeat (8) begin
			@(posedge ref_clk);
			n += cclk;
		end
		chk("conversion_clock", 32'h4, n);
		bus(1'b1, 5'h14, 32'hFFFFFFFF);
		bus(1'b0, 5'h14, 32'h0);
		chk("unmapped", 32'h0, q);
		foreach (codes[k]) begin
			bus(1'b1, sar_pkg::OFS_MUX, {27'h0, codes[k]});
			// core controls are registered behind the mux register
			repeat (2) @(posedge ref_clk);
			chk("chan", {27'h0, codes[k]}, {27'h0, ctl.chan});
			chk("connect", {31'h0, codes[k] <= 5'h13}, {31'h0, ctl.connect});
		end
		chk("res", {30'h0, sar_pkg::RES_12}, {30'h0, ctl.res});
		t0 = cyc;
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h1);
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h1);
		wait_done();
		chk("starts", 32'h1, starts);
		chk("quick", 32'h1, (last_st - t0) <= 4);
		chk("track", 32'h1, {31'h0, ctl.track});
		result(8'h02, 8'hA5);
		s0 = starts;
		@(posedge ref_clk) tovf <= 1'b1;
		ext <= 1'b1;
		@(posedge ref_clk) tovf <= 1'b0;
		ext <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("ignored", s0, starts);
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h08);
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h09);
		repeat (20) @(posedge ref_clk);
		chk("sw_ignored", s0, starts);
		@(posedge ref_clk) tovf <= 1'b1;
		@(posedge ref_clk) tovf <= 1'b0;
		wait_done();
		chk("timer", s0 + 1, starts);
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h10);
		ext <= 1'b1;
		wait_done();
		ext <= 1'b0;
		chk("pin", s0 + 2, starts);
		// pin held low sets the tracking time
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h14);
		repeat (2) @(posedge ref_clk);
		chk("pin_track", 32'h1, {31'h0, ctl.track});
		repeat (10) @(posedge ref_clk);
		chk("pin_wait", s0 + 2, starts);
		ext <= 1'b1;
		wait_done();
		ext <= 1'b0;
		chk("pin_conv", s0 + 3, starts);
		bus(1'b1, sar_pkg::OFS_CFG, 32'h0);
		// source must be software before the start bit counts
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h04);
		t0 = cyc;
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h05);
		wait_done();
		chk("delay", 32'h1, (last_st - t0) >= 8);
		s0 = starts;
		bus(1'b1, sar_pkg::OFS_CFG, 32'h0A0);
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h40);
		bus(1'b1, sar_pkg::OFS_CTRL, 32'h41);
		wait_done();
		chk("burst", s0 + 4, starts);
		result(8'h0A, 8'h90);
		chk("power", 32'h0, {31'h0, ctl.power});
		close_out();
	end
endmodule
